// file: design/txc_decoder.sv
// Transmit buffer command decoder with its APB register file.
// Assumes the host pushes command and payload dwords by APB writes to the data
// register; kept payload leaves on a one-cycle strobe toward the transmit FIFO.
//
// The register offsets and the APB register port were decided locally.

// Contract
// - Each buffer opens with two 32-bit words: command A then command B.
// - Differing command B within one packet raises the transmit error flag.
// - A 16-bit packet tag is taken from command B of the packet's last buffer.
// - The tag is returned with the status of its packet.
// - Command A bit 31 raises buffer loaded flag once the buffer is fully in.
// - Pad dwords at the buffer end are discarded, never transmitted.
// - Not every written word is stored; stored and dropped words are counted.
module txc_decoder (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             fifo_valid,
    output logic [31:0]      fifo_data,
    output logic             status_valid,
    output logic [15:0]      status_tag,
    output logic             irq
);

    // APB access phase in which a transfer completes
    logic        acc;
    logic        wr_acc;
    logic        data_push;
    logic        mapped;

    // APB answer registers
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // Decoder state
    txc_pkg::txc_state_t state;
    txc_pkg::txc_state_t next_state;
    logic [31:0]         cmd_a;
    logic [31:0]         next_cmd_a;
    logic [31:0]         cmd_b;
    logic [31:0]         next_cmd_b;
    logic                pkt_open;
    logic                next_pkt_open;
    logic [txc_pkg::DW_W-1:0] dw_idx;
    logic [txc_pkg::DW_W-1:0] next_dw_idx;
    logic [txc_pkg::CNT_W-1:0] kept_cnt;
    logic [txc_pkg::CNT_W-1:0] next_kept_cnt;
    logic [txc_pkg::CNT_W-1:0] drop_cnt;
    logic [txc_pkg::CNT_W-1:0] next_drop_cnt;
    logic                next_fifo_valid;
    logic [31:0]         next_fifo_data;
    logic                next_status_valid;
    logic [15:0]         next_status_tag;

    // Events and interrupt registers
    logic                       ev_done;
    logic                       ev_txe;
    logic [txc_pkg::INT_W-1:0]  int_en;
    logic [txc_pkg::INT_W-1:0]  next_int_en;
    logic [txc_pkg::INT_W-1:0]  int_sts;
    logic [txc_pkg::INT_W-1:0]  sts_clear;
    logic [txc_pkg::INT_W-1:0]  event_set;

    // Sizes of the buffer in progress
    logic [txc_pkg::DW_W-1:0] data_dw;
    logic [txc_pkg::DW_W-1:0] total_dw;
    logic                     align_bad;
    // Only the alignment check is taken from a word still on the bus
    logic                     new_align_bad;

    // Finish of a buffer: status and flags
    function automatic logic is_last_dw(
        input logic [txc_pkg::DW_W-1:0] idx,
        input logic [txc_pkg::DW_W-1:0] total
    );
        is_last_dw = (idx + 12'h001) == total;
    endfunction

    // Sizes for the stored command A; a freshly written one gets only its alignment check
    txc_pad_calc u_size (
        .cmd_a     (cmd_a),
        .data_dw   (data_dw),
        .total_dw  (total_dw),
        .align_bad (align_bad)
    );

    // Checks command A while it is written, before it is stored
    txc_pad_calc u_size_new (
        .cmd_a     (pwdata),
        .data_dw   (),
        .total_dw  (),
        .align_bad (new_align_bad)
    );

    txc_irq u_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .event_set (event_set),
        .sts_clear (sts_clear),
        .int_en    (int_en),
        .int_sts   (int_sts),
        .irq       (irq)
    );

    // APB decode; pready is high in the first cycle of the access phase
    always_comb
    begin
        acc       = psel && penable && pready;
        wr_acc    = acc && pwrite;
        data_push = wr_acc && (paddr == txc_pkg::ADDR_DATA);
        mapped    = (paddr == txc_pkg::ADDR_DATA) || (paddr == txc_pkg::ADDR_STATE)
                 || (paddr == txc_pkg::ADDR_INT_STS) || (paddr == txc_pkg::ADDR_INT_EN)
                 || (paddr == txc_pkg::ADDR_TAG) || (paddr == txc_pkg::ADDR_KEPT)
                 || (paddr == txc_pkg::ADDR_DROP);
        sts_clear = '0;
        next_int_en = int_en;
        if (wr_acc && paddr == txc_pkg::ADDR_INT_STS)
        begin
            sts_clear = pwdata[txc_pkg::INT_W-1:0];
        end
        if (wr_acc && paddr == txc_pkg::ADDR_INT_EN)
        begin
            next_int_en = pwdata[txc_pkg::INT_W-1:0];
        end
    end

    // Answer set up during the setup cycle so it is ready at the access edge
    always_comb
    begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata  = txc_pkg::WORD_RST;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                txc_pkg::ADDR_STATE:   next_prdata = {15'h0000, pkt_open, dw_idx, 2'h0, state};
                txc_pkg::ADDR_INT_STS: next_prdata = {30'h0000_0000, int_sts};
                txc_pkg::ADDR_INT_EN:  next_prdata = {30'h0000_0000, int_en};
                txc_pkg::ADDR_TAG:     next_prdata = cmd_b;
                txc_pkg::ADDR_KEPT:    next_prdata = {16'h0000, kept_cnt};
                txc_pkg::ADDR_DROP:    next_prdata = {16'h0000, drop_cnt};
                default:               next_prdata = txc_pkg::WORD_RST;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= txc_pkg::WORD_RST;
            int_en  <= txc_pkg::INT_EN_RST;
        end
        else
        begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
            int_en  <= next_int_en;
        end
    end

    // Command and payload sequencing, one dword per data register write
    always_comb
    begin
        next_state        = state;
        next_cmd_a        = cmd_a;
        next_cmd_b        = cmd_b;
        next_pkt_open     = pkt_open;
        next_dw_idx       = dw_idx;
        next_kept_cnt     = kept_cnt;
        next_drop_cnt     = drop_cnt;
        next_fifo_valid   = 1'b0;
        next_fifo_data    = fifo_data;
        next_status_valid = 1'b0;
        next_status_tag   = status_tag;
        ev_done           = 1'b0;
        ev_txe            = 1'b0;
        if (data_push)
        begin
            unique case (state)
                txc_pkg::ST_CMD_A:
                begin
                    // First dword of a buffer is always command A
                    next_cmd_a  = pwdata;
                    next_dw_idx = '0;
                    next_state  = txc_pkg::ST_CMD_B;
                    // Reserved alignment code cannot be honoured
                    if (new_align_bad)
                    begin
                        ev_txe = 1'b1;
                    end
                end
                txc_pkg::ST_CMD_B:
                begin
                    next_cmd_b = pwdata;
                    if (cmd_a[txc_pkg::A_FS_BIT])
                    begin
                        next_pkt_open = 1'b1;
                    end
                    else if (!pkt_open || pwdata != cmd_b)
                    begin
                        // Later buffer with no open packet, or with a command B differing from the packet's
                        ev_txe = 1'b1;
                    end
                    if (total_dw == '0)
                    begin
                        // Empty buffer completes as soon as its command is in
                        next_state = txc_pkg::ST_CMD_A;
                        ev_done    = cmd_a[txc_pkg::A_IOC_BIT];
                        if (cmd_a[txc_pkg::A_LS_BIT])
                        begin
                            next_status_valid = 1'b1;
                            next_status_tag   = pwdata[txc_pkg::B_TAG_HI:txc_pkg::B_TAG_LO];
                            next_pkt_open     = 1'b0;
                        end
                    end
                    else
                    begin
                        next_state = txc_pkg::ST_DATA;
                    end
                end
                txc_pkg::ST_DATA:
                begin
                    next_dw_idx = dw_idx + 12'h001;
                    if (dw_idx < data_dw)
                    begin
                        next_fifo_valid = 1'b1;
                        next_fifo_data  = pwdata;
                        next_kept_cnt   = kept_cnt + 16'h0001;
                    end
                    else
                    begin
                        // Pad dword past the payload is dropped
                        next_drop_cnt = drop_cnt + 16'h0001;
                    end
                    if (is_last_dw(dw_idx, total_dw))
                    begin
                        next_state = txc_pkg::ST_CMD_A;
                        ev_done    = cmd_a[txc_pkg::A_IOC_BIT];
                        if (cmd_a[txc_pkg::A_LS_BIT])
                        begin
                            next_status_valid = 1'b1;
                            next_status_tag   = cmd_b[txc_pkg::B_TAG_HI:txc_pkg::B_TAG_LO];
                            next_pkt_open     = 1'b0;
                        end
                    end
                end
            endcase
        end
        event_set = '0;
        event_set[txc_pkg::INT_DONE_BIT] = ev_done;
        event_set[txc_pkg::INT_TXE_BIT]  = ev_txe;
    end

    // Decoder registers; counters wrap silently, software reads differences
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= txc_pkg::ST_CMD_A;
            cmd_a        <= txc_pkg::WORD_RST;
            cmd_b        <= txc_pkg::WORD_RST;
            pkt_open     <= 1'b0;
            dw_idx       <= '0;
            kept_cnt     <= txc_pkg::CNT_RST;
            drop_cnt     <= txc_pkg::CNT_RST;
            fifo_valid   <= 1'b0;
            fifo_data    <= txc_pkg::WORD_RST;
            status_valid <= 1'b0;
            status_tag   <= txc_pkg::CNT_RST;
        end
        else
        begin
            state        <= next_state;
            cmd_a        <= next_cmd_a;
            cmd_b        <= next_cmd_b;
            pkt_open     <= next_pkt_open;
            dw_idx       <= next_dw_idx;
            kept_cnt     <= next_kept_cnt;
            drop_cnt     <= next_drop_cnt;
            fifo_valid   <= next_fifo_valid;
            fifo_data    <= next_fifo_data;
            status_valid <= next_status_valid;
            status_tag   <= next_status_tag;
        end
    end

endmodule

// file: design/txc_pkg.sv
// Package for the transmit buffer command decoder: register map, command word
// field positions, interrupt bit layout, reset values and decoder states.
// Assumes a 32-bit APB register bus with byte addresses on an 8-bit window.
package txc_pkg;

    // Register byte offsets
    localparam logic [7:0]  ADDR_DATA      = 8'h00;
    localparam logic [7:0]  ADDR_STATE     = 8'h04;
    localparam logic [7:0]  ADDR_INT_STS   = 8'h08;
    localparam logic [7:0]  ADDR_INT_EN    = 8'h0c;
    localparam logic [7:0]  ADDR_TAG       = 8'h10;
    localparam logic [7:0]  ADDR_KEPT      = 8'h14;
    localparam logic [7:0]  ADDR_DROP      = 8'h18;

    // Command A fields
    localparam int          A_IOC_BIT      = 31;
    localparam int          A_RSVD_HI      = 30;
    localparam int          A_RSVD_LO      = 26;
    localparam int          A_ALIGN_HI     = 25;
    localparam int          A_ALIGN_LO     = 24;
    localparam int          A_OFS_HI       = 20;
    localparam int          A_OFS_LO       = 16;
    localparam int          A_FS_BIT       = 13;
    localparam int          A_LS_BIT       = 12;
    localparam int          A_SIZE_HI      = 10;
    localparam int          A_SIZE_LO      = 0;

    // Command B fields
    localparam int          B_TAG_HI       = 31;
    localparam int          B_TAG_LO       = 16;

    // End alignment codes
    localparam logic [1:0]  ALIGN_4        = 2'h0;
    localparam logic [1:0]  ALIGN_16       = 2'h1;
    localparam logic [1:0]  ALIGN_32       = 2'h2;

    // Interrupt status and enable layout
    localparam int          INT_W          = 2;
    localparam int          INT_DONE_BIT   = 0;
    localparam int          INT_TXE_BIT    = 1;
    localparam logic [1:0]  INT_EN_RST     = 2'h0;

    // Widths and reset values of counters
    localparam int          DW_W           = 12;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_RST        = 16'h0000;
    localparam logic [31:0] WORD_RST       = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_CMD_A,
        ST_CMD_B,
        ST_DATA
    } txc_state_t;

endpackage

// file: design/txc_pad_calc.sv
// Size calculator for one transmit buffer, from its command A word.
// Assumes command A is stable while the results are used; purely combinational.
module txc_pad_calc (
    input  wire logic [31:0]             cmd_a,
    output logic      [txc_pkg::DW_W-1:0] data_dw,
    output logic      [txc_pkg::DW_W-1:0] total_dw,
    output logic                          align_bad
);

    // Round a dword count up to a multiple of (mask + 1)
    function automatic logic [txc_pkg::DW_W-1:0] round_up(
        input logic [txc_pkg::DW_W-1:0] value,
        input logic [txc_pkg::DW_W-1:0] mask
    );
        logic [txc_pkg::DW_W:0] sum;
        sum = {1'b0, value} + {1'b0, mask};
        round_up = sum[txc_pkg::DW_W-1:0] & ~mask;
    endfunction

    logic [12:0] byte_end;
    logic [1:0]  align;

    // Offset and size give the dwords that carry payload
    always_comb
    begin
        byte_end = 13'(cmd_a[txc_pkg::A_SIZE_HI:txc_pkg::A_SIZE_LO])
                 + 13'(cmd_a[txc_pkg::A_OFS_HI:txc_pkg::A_OFS_LO]) + 13'h3;
        data_dw  = {1'b0, byte_end[12:2]};
        align    = cmd_a[txc_pkg::A_ALIGN_HI:txc_pkg::A_ALIGN_LO];
        align_bad = 1'b0;
        // Host pads up to the chosen end alignment; these pads get dropped
        unique case (align)
            txc_pkg::ALIGN_4:  total_dw = data_dw;
            txc_pkg::ALIGN_16: total_dw = round_up(data_dw, 12'h003);
            txc_pkg::ALIGN_32: total_dw = round_up(data_dw, 12'h007);
            default:
            begin
                // Reserved code: treat as no padding and report it
                total_dw  = data_dw;
                align_bad = 1'b1;
            end
        endcase
    end

endmodule

// file: design/txc_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and one level output.
// Assumes event inputs are single-cycle pulses on pclk.
module txc_irq (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [txc_pkg::INT_W-1:0] event_set,
    input  wire logic [txc_pkg::INT_W-1:0] sts_clear,
    input  wire logic [txc_pkg::INT_W-1:0] int_en,
    output logic      [txc_pkg::INT_W-1:0] int_sts,
    output logic                           irq
);

    logic [txc_pkg::INT_W-1:0] next_int_sts;
    logic                      next_irq;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb
    begin
        next_int_sts = (int_sts & ~sts_clear) | event_set;
        next_irq     = |(next_int_sts & int_en);
    end

    // Registered so the interrupt pin is glitch free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_sts <= '0;
            irq     <= 1'b0;
        end
        else
        begin
            int_sts <= next_int_sts;
            irq     <= next_irq;
        end
    end

endmodule

// file: sim/txc_decoder_assertions.sv
// Port checker for the transmit command decoder, bound to every instance.
// Assumes one pclk domain and presetn active low.
module txc_decoder_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        fifo_valid,
    input wire logic [31:0] fifo_data,
    input wire logic        status_valid,
    input wire logic [15:0] status_tag,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Committed write, and committed push into the data register
    wire wc = psel && penable && pready && pwrite;
    wire dw = wc && (paddr == txc_pkg::ADDR_DATA);

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_needs_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    idle_read_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    // Only a pushed payload dword may reach the transmit side, and unchanged
    fifo_cause_a: assert property (fifo_valid |-> $past(dw) && fifo_data == $past(pwdata))
        else $error("fifo strobe without push");
    status_cause_a: assert property (status_valid |-> $past(dw))
        else $error("status without push");
    status_gap_a: assert property (status_valid |=> !status_valid)
        else $error("status strobe too long");
    tag_cause_a: assert property ($changed(status_tag) |-> $past(dw))
        else $error("tag changed without push");
    // Interrupt moves only after a committed register write
    irq_rise_a: assert property ($rose(irq) |-> $past(wc) || $past(wc, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(wc) || $past(wc, 2))
        else $error("irq fell without write");
endmodule

bind txc_decoder txc_decoder_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .status_valid(status_valid),
    .status_tag(status_tag), .irq(irq)
);

// file: sim/txc_host_model.sv
// Host model: an APB master that writes transmit buffers into the decoder.
// Assumes the decoder answers with pready; hangs are cut by the bench.
module txc_host_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus from time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Setup, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so stale values never look valid
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask

    // Command A, command B, then payload and pad dwords
    task automatic send(input logic [31:0] cmd_a, input logic [31:0] cmd_b,
                        input int n, input logic [31:0] base);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, txc_pkg::ADDR_DATA, cmd_a, r, e);
        xfer(1'b1, txc_pkg::ADDR_DATA, cmd_b, r, e);
        for (int i = 0; i < n; i++)
            xfer(1'b1, txc_pkg::ADDR_DATA, base + 32'(i), r, e);
    endtask
endmodule

// file: sim/txc_decoder_tb.sv
// Self-checking bench for the transmit command decoder.
// Assumes the host model as APB master and the bound port checker.
module txc_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        fifo_valid;
    logic [31:0] fifo_data;
    logic        status_valid;
    logic [15:0] status_tag;
    logic        irq;
    logic [31:0] r;
    logic        e;
    logic [31:0] last_fifo;
    int          errors = 0;
    int          samples_checked = 0;
    int          kept_n = 0;
    int          stat_n = 0;

    txc_decoder i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data), .status_valid(status_valid),
        .status_tag(status_tag), .irq(irq)
    );

    txc_host_model i_host (
        .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
    );

    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Strobes last one cycle, so each is counted once
    always @(posedge pclk)
    begin
        if (fifo_valid === 1'b1)
        begin
            kept_n++;
            last_fifo = fifo_data;
        end
        if (status_valid === 1'b1)
            stat_n++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, r, e);
    endtask

    // Reset values, read-only tag register and an unmapped address
    task automatic t_reset;
        chk({31'h0, irq}, 32'h0);
        rd(txc_pkg::ADDR_STATE, 32'h0);
        rd(txc_pkg::ADDR_INT_STS, 32'h0);
        rd(txc_pkg::ADDR_INT_EN, 32'h0);
        rd(txc_pkg::ADDR_KEPT, 32'h0);
        rd(txc_pkg::ADDR_DROP, 32'h0);
        wr(txc_pkg::ADDR_TAG, 32'hffff_ffff);
        rd(txc_pkg::ADDR_TAG, 32'h0);
        i_host.xfer(1'b0, 8'h1c, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    // Flagged buffer: payload kept, tag returned, interrupt masked then raised
    task automatic t_ioc;
        int k;
        int s;
        k = kept_n;
        s = stat_n;
        i_host.send(32'h8000_3008, 32'h1234_0008, 2, 32'ha5a5_0000);
        tick(3);
        chk(32'(kept_n - k), 32'h2);
        chk(last_fifo, 32'ha5a5_0001);
        chk(32'(stat_n - s), 32'h1);
        chk({16'h0, status_tag}, 32'h1234);
        rd(txc_pkg::ADDR_TAG, 32'h1234_0008);
        rd(txc_pkg::ADDR_INT_STS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(txc_pkg::ADDR_INT_EN, 32'h1);
        tick(3);
        chk({31'h0, irq}, 32'h1);
        wr(txc_pkg::ADDR_INT_STS, 32'h1);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        rd(txc_pkg::ADDR_INT_STS, 32'h0);
    endtask

    // Every alignment code: one dword kept, pad dwords dropped
    task automatic t_align;
        int          k;
        logic [31:0] d0;
        int          total[4] = '{1, 4, 8, 1};
        for (int c = 0; c < 4; c++)
        begin
            i_host.xfer(1'b0, txc_pkg::ADDR_DROP, 32'h0, d0, e);
            k = kept_n;
            i_host.send(32'h0000_3004 | (32'(c) << 24), {16'(c + 1), 16'h0004}, total[c], 32'h0);
            tick(3);
            chk(32'(kept_n - k), 32'h1);
            rd(txc_pkg::ADDR_DROP, d0 + 32'(total[c] - 1));
            rd(txc_pkg::ADDR_INT_STS, (c == 3) ? 32'h2 : 32'h0);
            wr(txc_pkg::ADDR_INT_STS, 32'h3);
        end
    endtask

    // Two-buffer packets, with matching and then differing command B
    task automatic t_packet;
        int s;
        for (int m = 0; m < 2; m++)
        begin
            s = stat_n;
            i_host.send(32'h0000_2004, 32'h5555_0008, 1, 32'h0);
            i_host.send(32'h8000_1004, (m == 1) ? 32'h7777_0008 : 32'h5555_0008, 1, 32'h0);
            tick(3);
            chk(32'(stat_n - s), 32'h1);
            rd(txc_pkg::ADDR_INT_STS, (m == 1) ? 32'h3 : 32'h1);
            wr(txc_pkg::ADDR_INT_STS, 32'h3);
        end
    endtask

    // Zero-size buffers finish on command B; a later segment with no open packet is an error
    task automatic t_empty;
        int s;
        s = stat_n;
        i_host.send(32'h8000_3000, 32'h4321_0000, 0, 32'h0);
        tick(3);
        chk(32'(stat_n - s), 32'h1);
        chk({16'h0, status_tag}, 32'h4321);
        chk({31'h0, irq}, 32'h1);
        i_host.send(32'h0000_1000, 32'h4321_0000, 0, 32'h0);
        tick(3);
        rd(txc_pkg::ADDR_INT_STS, 32'h3);
        wr(txc_pkg::ADDR_INT_STS, 32'h3);
        tick(3);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic complete_run;
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence after 12 cycles of reset
    initial
    begin
        presetn = 1'b0;
        tick(12);
        presetn <= 1'b1;
        t_reset();
        t_ioc();
        t_align();
        t_packet();
        t_empty();
        complete_run();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        #400000;
        errors++;
        complete_run();
    end
endmodule
